// File: ddf_pkg.sv
// Shared constants for the dual-direction FIFO transceiver.
// Assumes one core clock; every pin input is synchronous to it.
package ddf_pkg;

    // ==============================================================
    // Storage geometry
    localparam int          DATA_W      = 18;
    localparam int          ADDR_W      = 9;
    localparam int          CNT_W       = 10;
    localparam int          OFF_W       = 8;
    localparam logic [9:0]  FIFO_DEPTH  = 10'h200;  // 512 words
    localparam logic [9:0]  HALF_LEVEL  = 10'h100;  // 256 words
    localparam logic [7:0]  DEF_OFFSET  = 8'h80;    // 128 words

    // ==============================================================
    // Register map, byte addresses on AXI4-Lite
    localparam int          AXI_AW      = 8;
    localparam logic [7:0]  REG_CTRL    = 8'h00;
    localparam logic [7:0]  REG_STATUS  = 8'h04;
    localparam logic [7:0]  REG_COUNT   = 8'h08;
    localparam logic [7:0]  REG_OFFSET  = 8'h0C;

    // Control bits (write one, self clearing)
    localparam int          CTRL_CLR_AB = 0;
    localparam int          CTRL_CLR_BA = 1;

    // Status field positions, one nibble per direction
    localparam int          ST_NEMPTY   = 0;
    localparam int          ST_NFULL    = 1;
    localparam int          ST_HALF     = 2;
    localparam int          ST_NEAR     = 3;
    localparam int          ST_BA_BASE  = 8;

    // Count and offset field positions
    localparam int          CNT_BA_BASE = 16;
    localparam int          OFF_BA_BASE = 16;
    localparam int          OFF_Y_BASE  = 8;

    // AXI responses
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // Offset programming sequence
    typedef enum logic [1:0] {
        PROG_IDLE  = 2'b00,
        PROG_FIRST = 2'b01,
        PROG_DONE  = 2'b10
    } ddf_prog_e;

endpackage : ddf_pkg

// File: ddf_chan_if.sv
// Per-direction bundle between the core, its storage and the registers.
// Assumes instantiation inside the top, one per direction.
`timescale 1ns/1ns
`default_nettype none
interface ddf_chan_if;
    import ddf_pkg::*;
    logic                wr;         // Store one word
    logic                rd;         // Advance to next word
    logic                clr;        // Empty the store
    logic [DATA_W-1:0]   din;        // Word to store
    logic [CNT_W-1:0]    count;      // Words held
    logic [DATA_W-1:0]   head;       // Oldest word
    logic [3:0]          flags;      // Near, half, not full, not empty
    logic [OFF_W-1:0]    off_x;      // Almost-empty offset
    logic [OFF_W-1:0]    off_y;      // Almost-full offset
    logic                soft_clr;   // Software clear pulse

    modport store (input wr, input rd, input clr, input din,
                   output count, output head);
    modport regs  (input count, input flags, input off_x, input off_y,
                   output soft_clr);
endinterface : ddf_chan_if
`default_nettype wire

// File: ddf_fifo_store.sv
// 512 x 18 storage with first-word fall-through head register.
// Assumes wr only when not full and rd only when not empty.
`timescale 1ns/1ns
`default_nettype none
module ddf_fifo_store
    import ddf_pkg::*;
(
    input  wire logic   clk,
    input  wire logic   rst,
    ddf_chan_if.store   ch
);
    logic [DATA_W-1:0]  mem [0:511];
    logic [ADDR_W-1:0]  wr_ptr_r;
    logic [ADDR_W-1:0]  rd_ptr_r;
    logic [CNT_W-1:0]   count_r;
    logic [DATA_W-1:0]  head_r;
    logic [ADDR_W-1:0]  rd_ptr_nxt;
    logic [CNT_W-1:0]   count_nxt;
    logic [DATA_W-1:0]  head_nxt;

    // ==============================================================
    // Next pointer, count and head word
    assign rd_ptr_nxt = ch.rd ? rd_ptr_r + 9'h001 : rd_ptr_r;
    assign count_nxt  = count_r + {9'h000, ch.wr} - {9'h000, ch.rd};
    // A word landing where the head will sit is shown at once
    assign head_nxt   = (ch.wr && rd_ptr_nxt == wr_ptr_r) ? ch.din : mem[rd_ptr_nxt];
    assign ch.count   = count_r;
    assign ch.head    = head_r;

    // Memory write
    always_ff @(posedge clk)
    begin
        if (ch.wr)
            mem[wr_ptr_r] <= ch.din;
    end

    // Pointers, count and head
    always_ff @(posedge clk)
    begin
        if (rst || ch.clr)
        begin
            wr_ptr_r <= 9'h000;
            rd_ptr_r <= 9'h000;
            count_r  <= 10'h000;
            head_r   <= 18'h0_0000;
        end
        else
        begin
            if (ch.wr)
                wr_ptr_r <= wr_ptr_r + 9'h001;
            rd_ptr_r <= rd_ptr_nxt;
            count_r  <= count_nxt;
            if (count_nxt != 10'h000)
                head_r <= head_nxt;
        end
    end
endmodule : ddf_fifo_store
`default_nettype wire

// File: ddf_axi_regs.sv
// AXI4-Lite slave: control, status, counts and offsets of both FIFOs.
// Assumes one write and one read outstanding at most.
`timescale 1ns/1ns
`default_nettype none
module ddf_axi_regs
    import ddf_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic [AXI_AW-1:0]  s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [AXI_AW-1:0]  s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    ddf_chan_if.regs                ab,
    ddf_chan_if.regs                ba
);
    logic                aw_have_r;
    logic                w_have_r;
    logic [AXI_AW-1:0]   awaddr_r;
    logic [31:0]         wdata_r;
    logic [3:0]          wstrb_r;
    logic                bvalid_r;
    logic [1:0]          bresp_r;
    logic                rvalid_r;
    logic [31:0]         rdata_r;
    logic [1:0]          rresp_r;
    logic [1:0]          clr_r;
    logic                aw_take;
    logic                w_take;
    logic                wr_go;
    logic                ar_take;
    logic                wr_hit;
    logic                rd_hit;
    logic [31:0]         rd_word;

    // ==============================================================
    // Handshakes and decode
    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take  = s_axi_wvalid && s_axi_wready;
    assign wr_go   = aw_have_r && w_have_r && !bvalid_r;
    assign ar_take = s_axi_arvalid && s_axi_arready;
    assign wr_hit  = (awaddr_r == REG_CTRL) || (awaddr_r == REG_STATUS)
                  || (awaddr_r == REG_COUNT) || (awaddr_r == REG_OFFSET);
    assign rd_hit  = (s_axi_araddr == REG_CTRL) || (s_axi_araddr == REG_STATUS)
                  || (s_axi_araddr == REG_COUNT) || (s_axi_araddr == REG_OFFSET);

    // Read multiplexer
    assign rd_word = (s_axi_araddr == REG_STATUS) ? {20'h0_0000, ba.flags, 4'h0, ab.flags}
                   : (s_axi_araddr == REG_COUNT)  ? {6'h00, ba.count, 6'h00, ab.count}
                   : (s_axi_araddr == REG_OFFSET) ? {ba.off_y, ba.off_x, ab.off_y, ab.off_x}
                   : 32'h0000_0000;

    assign s_axi_awready = !aw_have_r;
    assign s_axi_wready  = !w_have_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;
    assign ab.soft_clr   = clr_r[CTRL_CLR_AB];
    assign ba.soft_clr   = clr_r[CTRL_CLR_BA];

    // Write channel: address and data in either order, then response
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            aw_have_r <= 1'b0;
            w_have_r  <= 1'b0;
            awaddr_r  <= 8'h00;
            wdata_r   <= 32'h0000_0000;
            wstrb_r   <= 4'h0;
            bvalid_r  <= 1'b0;
            bresp_r   <= RESP_OKAY;
            clr_r     <= 2'h0;
        end
        else
        begin
            clr_r <= 2'h0;
            if (aw_take)
            begin
                aw_have_r <= 1'b1;
                awaddr_r  <= s_axi_awaddr;
            end
            if (w_take)
            begin
                w_have_r <= 1'b1;
                wdata_r  <= s_axi_wdata;
                wstrb_r  <= s_axi_wstrb;
            end
            if (wr_go)
            begin
                aw_have_r <= 1'b0;
                w_have_r  <= 1'b0;
                bvalid_r  <= 1'b1;
                bresp_r   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
                if (awaddr_r == REG_CTRL && wstrb_r[0])
                    clr_r <= wdata_r[1:0];
            end
            else if (bvalid_r && s_axi_bready)
                bvalid_r <= 1'b0;
        end
    end

    // Read channel
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= RESP_OKAY;
        end
        else if (ar_take)
        begin
            rvalid_r <= 1'b1;
            rdata_r  <= rd_word;
            rresp_r  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (rvalid_r && s_axi_rready)
            rvalid_r <= 1'b0;
    end
endmodule : ddf_axi_regs
`default_nettype wire

// File: ddf_transceiver.sv
// Top of the dual-direction FIFO transceiver: two 512 x 18 FIFOs,
// A-to-B and B-to-A, with bus source selects, drive enables, flags,
// programmable near-limit offsets and an AXI4-Lite register window.
// Assumes every strobe pin is synchronous to core_clk and held for at
// least one core clock high and one low; a strobe is acted on at the
// core clock edge that first sees it high.
`timescale 1ns/1ns
`default_nettype none
module ddf_transceiver
    import ddf_pkg::*;
(
    input  wire logic               core_clk,
    input  wire logic               sys_rst,
    // Bus A
    input  wire logic [DATA_W-1:0]  port_a_data_in,
    output logic [DATA_W-1:0]       port_a_data_out,
    output logic                    port_a_data_oe,
    // Bus B
    input  wire logic [DATA_W-1:0]  port_b_data_in,
    output logic [DATA_W-1:0]       port_b_data_out,
    output logic                    port_b_data_oe,
    // A-to-B FIFO control
    input  wire logic               load_clock_ab,
    input  wire logic               unload_clock_ab,
    input  wire logic               offset_program_enable_ab_n,
    input  wire logic               fifo_clear_ab_n,
    // B-to-A FIFO control
    input  wire logic               load_clock_ba,
    input  wire logic               unload_clock_ba,
    input  wire logic               offset_program_enable_ba_n,
    input  wire logic               fifo_clear_ba_n,
    // Bus selects and enables
    input  wire logic               port_b_source_select,
    input  wire logic               port_a_source_select,
    input  wire logic               port_b_drive_enable,
    input  wire logic               port_a_drive_enable,
    // Flags
    output logic                    not_full_ab,
    output logic                    not_empty_ab,
    output logic                    half_full_ab,
    output logic                    near_limit_ab,
    output logic                    not_full_ba,
    output logic                    not_empty_ba,
    output logic                    half_full_ba,
    output logic                    near_limit_ba,
    // AXI4-Lite
    input  wire logic [AXI_AW-1:0]  s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [AXI_AW-1:0]  s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready
);

    // ==============================================================
    // Flag evaluation
    // Near-limit: at most X words, or at least 512 - Y words
    function automatic logic near_limit_of(input logic [CNT_W-1:0] cnt,
                                           input logic [OFF_W-1:0] x,
                                           input logic [OFF_W-1:0] y);
        logic [CNT_W-1:0] hi_mark;
        hi_mark = FIFO_DEPTH - {2'h0, y};
        return (cnt <= {2'h0, x}) || (cnt >= hi_mark);
    endfunction : near_limit_of

    // Flag nibble: near, half, not full, not empty
    function automatic logic [3:0] flags_of(input logic [CNT_W-1:0] cnt,
                                            input logic [OFF_W-1:0] x,
                                            input logic [OFF_W-1:0] y);
        logic [3:0] f;
        f           = 4'h0;
        f[ST_NEMPTY] = (cnt != 10'h000);
        f[ST_NFULL]  = (cnt != FIFO_DEPTH);
        f[ST_HALF]   = (cnt >= HALF_LEVEL);
        f[ST_NEAR]   = near_limit_of(cnt, x, y);
        return f;
    endfunction : flags_of

    // ==============================================================
    // Channel bundles: index 0 is A-to-B, index 1 is B-to-A
    ddf_chan_if chan [2] ();

    logic [1:0]          ld_clk;
    logic [1:0]          ul_clk;
    logic [1:0]          prog_n;
    logic [1:0]          clear_n;
    logic [1:0]          src_sel;
    logic [1:0]          drv_en;
    logic [DATA_W-1:0]   src_data [2];
    logic [DATA_W-1:0]   dst_data_r [2];
    logic                dst_oe_r [2];
    logic [3:0]          flags_r [2];

    // Pin gathering; each direction programs from its own pins
    assign ld_clk      = {load_clock_ba, load_clock_ab};
    assign ul_clk      = {unload_clock_ba, unload_clock_ab};
    assign prog_n      = {offset_program_enable_ba_n, offset_program_enable_ab_n};
    assign clear_n     = {fifo_clear_ba_n, fifo_clear_ab_n};
    assign src_sel     = {port_a_source_select, port_b_source_select};
    assign drv_en      = {port_a_drive_enable, port_b_drive_enable};
    assign src_data[0] = port_a_data_in;
    assign src_data[1] = port_b_data_in;

    // ==============================================================
    // Per-direction logic
    for (genvar g = 0; g < 2; g++)
    begin : g_dir
        logic                ld_prev_r;
        logic                ul_prev_r;
        logic                prog_open_r;
        ddf_prog_e           prog_st_r;
        logic [OFF_W-1:0]    off_x_r;
        logic [OFF_W-1:0]    off_y_r;
        logic                ld_edge;
        logic                ul_edge;
        logic                clr;
        logic                prog_edge;
        logic                can_wr;
        logic                can_rd;
        logic [CNT_W-1:0]    cnt_nxt;

        // Strobe edges and qualified storage actions
        assign ld_edge   = ld_clk[g] && !ld_prev_r;
        assign ul_edge   = ul_clk[g] && !ul_prev_r;
        assign clr       = sys_rst || !clear_n[g] || chan[g].soft_clr;
        assign prog_edge = ld_edge && !prog_n[g] && prog_open_r;
        assign can_wr    = ld_edge && !prog_edge
                        && (chan[g].count != FIFO_DEPTH);
        assign can_rd    = ul_edge && (chan[g].count != 10'h000);
        assign cnt_nxt   = chan[g].count + {9'h000, can_wr} - {9'h000, can_rd};

        assign chan[g].wr    = can_wr && !clr;
        assign chan[g].rd    = can_rd && !clr;
        assign chan[g].clr   = clr;
        assign chan[g].din   = src_data[g];
        assign chan[g].flags = flags_r[g];
        assign chan[g].off_x = off_x_r;
        assign chan[g].off_y = off_y_r;

        // Previous strobe levels for edge detection
        always_ff @(posedge core_clk)
        begin
            if (sys_rst)
            begin
                ld_prev_r <= 1'b0;
                ul_prev_r <= 1'b0;
            end
            else
            begin
                ld_prev_r <= ld_clk[g];
                ul_prev_r <= ul_clk[g];
            end
        end

        // Offset programming window and sequence
        always_ff @(posedge core_clk)
        begin
            if (clr)
            begin
                prog_open_r <= 1'b1;
                prog_st_r   <= PROG_IDLE;
                off_x_r     <= DEF_OFFSET;
                off_y_r     <= DEF_OFFSET;
            end
            else if (prog_edge)
            begin
                unique case (prog_st_r)
                    PROG_IDLE:
                    begin
                        off_x_r   <= src_data[g][OFF_W-1:0];
                        off_y_r   <= src_data[g][OFF_W-1:0];
                        prog_st_r <= PROG_FIRST;
                    end
                    PROG_FIRST:
                    begin
                        off_y_r   <= src_data[g][OFF_W-1:0];
                        prog_st_r <= PROG_DONE;
                    end
                    PROG_DONE:
                        prog_st_r <= PROG_DONE;
                    default:
                        prog_st_r <= PROG_IDLE;
                endcase
            end
            else
            begin
                if (can_wr)
                    prog_open_r <= 1'b0;
                if (prog_n[g])
                    prog_st_r <= PROG_IDLE;
            end
        end

        // Registered flags follow the count after this edge
        always_ff @(posedge core_clk)
        begin
            if (clr)
                flags_r[g] <= 4'ha;  // near high, full inactive
            else
                flags_r[g] <= flags_of(cnt_nxt, off_x_r, off_y_r);
        end

        // Output bus: select mux ahead of the output register gives a clean switch-over
        always_ff @(posedge core_clk)
        begin
            if (sys_rst)
            begin
                dst_data_r[g] <= 18'h0_0000;
                dst_oe_r[g]   <= 1'b0;
            end
            else
            begin
                dst_data_r[g] <= src_sel[g] ? chan[g].head : src_data[g];
                dst_oe_r[g]   <= drv_en[g];
            end
        end

        ddf_fifo_store u_store
        (
            .clk (core_clk),
            .rst (sys_rst),
            .ch  (chan[g])
        );
    end

    // ==============================================================
    // Pin outputs, each straight from a flip-flop
    assign port_b_data_out = dst_data_r[0];
    assign port_b_data_oe  = dst_oe_r[0];
    assign port_a_data_out = dst_data_r[1];
    assign port_a_data_oe  = dst_oe_r[1];
    assign not_empty_ab    = flags_r[0][ST_NEMPTY];
    assign not_full_ab     = flags_r[0][ST_NFULL];
    assign half_full_ab    = flags_r[0][ST_HALF];
    assign near_limit_ab   = flags_r[0][ST_NEAR];
    assign not_empty_ba    = flags_r[1][ST_NEMPTY];
    assign not_full_ba     = flags_r[1][ST_NFULL];
    assign half_full_ba    = flags_r[1][ST_HALF];
    assign near_limit_ba   = flags_r[1][ST_NEAR];

    // ==============================================================
    // Register window
    ddf_axi_regs u_regs
    (
        .clk            (core_clk),
        .rst            (sys_rst),
        .s_axi_awaddr   (s_axi_awaddr),
        .s_axi_awvalid  (s_axi_awvalid),
        .s_axi_awready  (s_axi_awready),
        .s_axi_wdata    (s_axi_wdata),
        .s_axi_wstrb    (s_axi_wstrb),
        .s_axi_wvalid   (s_axi_wvalid),
        .s_axi_wready   (s_axi_wready),
        .s_axi_bresp    (s_axi_bresp),
        .s_axi_bvalid   (s_axi_bvalid),
        .s_axi_bready   (s_axi_bready),
        .s_axi_araddr   (s_axi_araddr),
        .s_axi_arvalid  (s_axi_arvalid),
        .s_axi_arready  (s_axi_arready),
        .s_axi_rdata    (s_axi_rdata),
        .s_axi_rresp    (s_axi_rresp),
        .s_axi_rvalid   (s_axi_rvalid),
        .s_axi_rready   (s_axi_rready),
        .ab             (chan[0]),
        .ba             (chan[1])
    );

endmodule : ddf_transceiver
`default_nettype wire

// File: ddf_transceiver_end.sv
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// File: ddf_chk_checker.sv
// Checker on the top ports of the transceiver, A-to-B direction.
// Assumes binding into ddf_transceiver; one core clock domain.
`timescale 1ns/1ns
`default_nettype none
module ddf_chk
    import ddf_pkg::*;
(
    input wire logic              core_clk,
    input wire logic              sys_rst,
    input wire logic              load_clock_ab,
    input wire logic              unload_clock_ab,
    input wire logic              offset_program_enable_ab_n,
    input wire logic              fifo_clear_ab_n,
    input wire logic              port_b_source_select,
    input wire logic              port_b_drive_enable,
    input wire logic [DATA_W-1:0] port_a_data_in,
    input wire logic [DATA_W-1:0] port_b_data_out,
    input wire logic              port_b_data_oe,
    input wire logic              not_empty_ab,
    input wire logic              not_full_ab,
    input wire logic              half_full_ab,
    input wire logic              near_limit_ab
);
    // ====
    // Flag and bus relations
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    clear_flags_a: assert property (!fifo_clear_ab_n |=>
        !not_empty_ab && not_full_ab && !half_full_ab && near_limit_ab) else $error("clear flags");
    drive_follow_a: assert property (1'b1 |=>
        port_b_data_oe == $past(port_b_drive_enable)) else $error("drive enable");
    live_path_a: assert property (!port_b_source_select |=>
        port_b_data_out == $past(port_a_data_in)) else $error("live path");
    load_fill_a: assert property ($rose(load_clock_ab) && offset_program_enable_ab_n
        && fifo_clear_ab_n |=> not_empty_ab) else $error("load lost");
    idle_unload_a: assert property ($rose(unload_clock_ab) && !not_empty_ab
        && !$rose(load_clock_ab) |=> !not_empty_ab) else $error("unload when empty");
    half_data_a: assert property (half_full_ab |-> not_empty_ab) else $error("half");
    empty_near_a: assert property (!not_empty_ab |-> near_limit_ab) else $error("near");
    full_flags_a: assert property (!not_full_ab |-> half_full_ab && near_limit_ab)
        else $error("full flags");
endmodule : ddf_chk
bind ddf_transceiver ddf_chk u_chk (.*);
`default_nettype wire

// File: ddf_host_model.sv
// Host logic on both buses: makes load and unload strobes.
// Assumes requests are levels sampled on the core clock.
`timescale 1ns/1ns
`default_nettype none
module ddf_host_model (
    input  wire logic       clk,
    input  wire logic [3:0] req,
    output logic      [3:0] stb
);
    // ====
    // Strobes: high on every other cycle while a request is held, low otherwise
    initial stb = 4'h0;
    always @(posedge clk) stb <= req & ~stb;
endmodule : ddf_host_model
`default_nettype wire

// File: tb_top.sv
// Bench: strobes via the host model, registers over AXI4-Lite.
// Assumes the package, design, checker and host model come first.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import ddf_pkg::*;
    logic core_clk, port_a_data_oe, port_b_data_oe, s_axi_awready, s_axi_wready, s_axi_rvalid;
    logic not_full_ab, not_empty_ab, half_full_ab, near_limit_ab, s_axi_bvalid;
    logic not_full_ba, not_empty_ba, half_full_ba, near_limit_ba, s_axi_arready;
    logic sys_rst = 1'b1, port_b_source_select = 1'b0, port_a_source_select = 1'b1;
    logic port_b_drive_enable = 1'b0, port_a_drive_enable = 1'b0, fifo_clear_ab_n = 1'b1;
    logic offset_program_enable_ab_n = 1'b1, offset_program_enable_ba_n = 1'b1, s_axi_rready = '0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic [DATA_W-1:0] port_a_data_in, port_a_data_out, port_b_data_in, port_b_data_out;
    logic [DATA_W-1:0] bus_a = '0, bus_b = '0;
    logic [AXI_AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd_q;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs_q;
    logic [3:0] req = 4'h0, stb;
    int err_count = 0, total_checks = 0, i;
    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    ddf_transceiver DUT (.*, .s_axi_wstrb(4'hf), .load_clock_ab(stb[0]), .load_clock_ba(stb[1]),
        .unload_clock_ab(stb[2]), .unload_clock_ba(stb[3]),
        .fifo_clear_ba_n(1'b1));
    ddf_host_model u_host (.clk(core_clk), .req(req), .stb(stb));
    // Wire level of each bus from all drivers
    assign port_a_data_in = port_a_data_oe ? port_a_data_out : bus_a;
    assign port_b_data_in = port_b_data_oe ? port_b_data_out : bus_b;
    task automatic results(input bit t);
        err_count += t;
        $display("errors %0d checks %0d", err_count, total_checks);
        if (err_count == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : results
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // One AXI transfer; each channel held until its own ready
    task automatic axi(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge core_clk);
        {s_axi_awaddr, s_axi_araddr} <= {a, a};
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
        {s_axi_arvalid, s_axi_rready} <= {2{!w}};
        for (n = 0; n < 50; n++)
        begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready || s_axi_rvalid && s_axi_rready) break;
        end
        rd_q = s_axi_rdata;
        rs_q = w ? s_axi_bresp : s_axi_rresp;
        {s_axi_bready, s_axi_rready} <= 2'b00;
        if (n == 50) results(1'b1);
    endtask : axi
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        axi(1'b0, a, 32'h0);
        chk(nm, rd_q, e);
    endtask : rchk
    // One strobe request with the word on both buses
    task automatic pulse(input logic [3:0] m, input logic [DATA_W-1:0] d);
        @(posedge core_clk);
        {bus_a, bus_b, req} <= {d, d, m};
        @(posedge core_clk);
        req <= 4'h0;
        repeat (3) @(posedge core_clk);
    endtask : pulse
    // ====
    // Main sequence
    initial
    begin
        repeat (8) @(posedge core_clk);
        sys_rst <= 1'b0;
        rchk("status", REG_STATUS, 32'h0000_0a0a);
        rchk("offset", REG_OFFSET, 32'h8080_8080);
        axi(1'b0, 8'h10, 32'h0);
        chk("resp", {30'h0, rs_q}, {30'h0, RESP_SLVERR});
        {offset_program_enable_ab_n, offset_program_enable_ba_n} <= 2'b00;
        pulse(4'h3, 18'h3_ff03);
        pulse(4'h3, 18'h2_0005);
        {offset_program_enable_ab_n, offset_program_enable_ba_n} <= 2'b11;
        rchk("offset", REG_OFFSET, 32'h0503_0503);
        rchk("count", REG_COUNT, 32'h0);
        {port_b_source_select, port_b_drive_enable} <= 2'b11;
        for (i = 1; i <= 4; i++)
        begin
            pulse(4'h1, 18'h2_a5a0 + i[17:0]);
            chk("head", port_b_data_out, 18'h2_a5a1);
            if (i > 2) rchk("near", REG_STATUS, i == 3 ? 32'h0000_0a0b : 32'h0000_0a03);
        end
        chk("oe", port_b_data_oe, 1'b1);
        pulse(4'h4, 18'h0);
        chk("next", port_b_data_out, 18'h2_a5a2);
        {port_b_drive_enable, offset_program_enable_ab_n} <= 2'b00;
        pulse(4'h2, 18'h1_2345);
        chk("a bus", port_a_data_out, 18'h1_2345);
        chk("ba pins", {port_a_data_oe, not_empty_ba, not_full_ba, half_full_ba, near_limit_ba}, 5'h0d);
        rchk("status", REG_STATUS, 32'h0000_0b0b);
        repeat (510) pulse(4'h1, 18'h0);
        rchk("full", REG_STATUS, 32'h0000_0b0d);
        rchk("count", REG_COUNT, 32'h0001_0200);
        fifo_clear_ab_n <= 1'b0;
        @(posedge core_clk);
        fifo_clear_ab_n <= 1'b1;
        axi(1'b1, REG_CTRL, 32'h2);
        pulse(4'h4, 18'h0);
        rchk("clear", REG_STATUS, 32'h0000_0a0a);
        rchk("offset", REG_OFFSET, 32'h8080_8080);
        results(1'b0);
    end
endmodule : tb_top
`default_nettype wire
